// File: src/crx_defs.svh
// offsets, field positions, reset values and sizes for the can receive path
`ifndef CRX_DEFS_SVH
`define CRX_DEFS_SVH

// register offsets on the plain register port
`define CRX_ADDR_W          8
`define CRX_OFF_CONFIG      8'h00
`define CRX_OFF_FLAGS       8'h01
`define CRX_OFF_VALUE0      8'h10
`define CRX_OFF_MASK0       8'h18
`define CRX_OFF_FG0         8'h20

// filter configuration fields
`define CRX_CFG_MODE_LSB    4
`define CRX_CFG_HIT_LSB     0
`define CRX_CFG_RESET       8'h00
`define CRX_MODE_W32        2'h0
`define CRX_MODE_W16        2'h1
`define CRX_MODE_W8         2'h2
`define CRX_MODE_CLOSED     2'h3

// flag register fields
`define CRX_FLG_FULL        0
`define CRX_FLG_OVERRUN     1
`define CRX_FLG_RXEVT       2

// message storage
`define CRX_STAGES          5
`define CRX_MSG_BYTES       15
`define CRX_PTR_W           3

`endif

// File: src/crx_filt_if.sv
// interface carrying identifier bytes and filter result
`timescale 1ns/10ps
interface crx_filt_if;
    logic [7:0] id_byte [0:3];
    logic [1:0] mode;
    logic       hit;
    logic [2:0] hit_index;
    modport top  (output id_byte, output mode, input hit, input hit_index);
    modport filt (input id_byte, input mode, output hit, output hit_index);
endinterface

// File: src/crx_filter.sv
// acceptance filter: two 32-bit banks split by mode
`timescale 1ns/10ps
`include "crx_defs.svh"
module crx_filter (
    // identifier and result
    crx_filt_if.filt         fi,
    // value and mask bytes
    input  wire logic [63:0] VALUE,
    input  wire logic [63:0] MASK
);

    // bits with mask one are ignored, zero bits compared
    function automatic logic byte_ok(input logic [7:0] id,
                                     input logic [7:0] v,
                                     input logic [7:0] m);
        byte_ok = &(~(id ^ v) | m);
    endfunction

    logic [7:0] ok;
    logic [7:0] hits;

    always_comb begin
        for (int b = 0; b < 8; b++) begin
            ok[b] = byte_ok(fi.id_byte[b % 4], VALUE[b*8 +: 8],
                            MASK[b*8 +: 8]);
        end
        hits = 8'h00;
        unique case (fi.mode)
            `CRX_MODE_W32: begin
                hits[0] = &ok[3:0];
                hits[1] = &ok[7:4];
            end
            `CRX_MODE_W16: begin
                // every half-bank filter looks at identifier bytes 0 and 1
                hits[0] = &ok[1:0];
                hits[1] = byte_ok(fi.id_byte[0], VALUE[23:16],
                                  MASK[23:16]) &
                          byte_ok(fi.id_byte[1], VALUE[31:24],
                                  MASK[31:24]);
                hits[2] = &ok[5:4];
                hits[3] = byte_ok(fi.id_byte[0], VALUE[55:48],
                                  MASK[55:48]) &
                          byte_ok(fi.id_byte[1], VALUE[63:56],
                                  MASK[63:56]);
            end
            `CRX_MODE_W8: begin
                for (int b = 0; b < 8; b++) begin
                    hits[b] = byte_ok(fi.id_byte[0], VALUE[b*8 +: 8],
                                      MASK[b*8 +: 8]);
                end
            end
            `CRX_MODE_CLOSED: begin
                hits = 8'h00;
            end
        endcase
        fi.hit       = |hits;
        fi.hit_index = 3'h0;
        for (int b = 7; b >= 0; b--) begin
            if (hits[b]) begin
                fi.hit_index = 3'(b);
            end
        end
    end

endmodule // crx_filter

// File: src/crx_pkg.sv
// types shared by the can receive path
package crx_pkg;

    typedef logic [7:0] crx_byte_type;
    typedef crx_byte_type [14:0] crx_msg_type;

    typedef enum logic [2:0] {
        CRX_IDLE  = 3'b001,
        CRX_FRAME = 3'b010,
        CRX_DONE  = 3'b100
    } crx_state_type;

endpackage

// File: src/crx_rx.sv
// can receive path: background buffer, five-stage fifo, acceptance filter
//
// Notes on behaviour
// - accepted messages go into a five-stage fifo behind one window
// - background buffer private; only foreground buffer is readable
// - every buffer holds 15 bytes: id, control, data, stamp
// - full flag set while foreground holds an accepted good message
// - frame bytes written to background while filter evaluates
// - valid message moves into fifo, sets full flag, raises event
// - a frame right after interframe space lands in background
// - bad or rejected frame is dropped and overwritten next time
// - own transmitted frame is not stored, signalled or acknowledged
// - loopback treats own frames like any other frame
// - lost arbitration turns the frame into a normal received one
// - accepted frame with fifo full is discarded and overrun raised
// - full fifo still lets transmit run; accepts once a stage frees
// - value registers give identifier patterns; masks mark don't-care
// - mask zero compares the bit, mask one ignores it
// - three-bit hit index names lowest matching filter
// - config register splits banks into sizes or closes filter
// - 32-bit mode: two filters, hits 0 and 1
// - 16-bit mode: four filters, hits 0..3
// - 8-bit mode: eight filters on first identifier byte
// - closed filter never stores a message or sets full flag
`timescale 1ns/10ps
`include "crx_defs.svh"
module crx_rx (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RESET_N,
    // register port
    input  wire logic [`CRX_ADDR_W-1:0]  ADDR,
    input  wire logic [7:0]              WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [7:0]              RDATA,
    // frame from the protocol engine
    input  wire logic                    FRAME_START,
    input  wire logic                    BYTE_VALID,
    input  wire logic [7:0]              BYTE_DATA,
    input  wire logic                    FRAME_OK,
    input  wire logic                    FRAME_ERR,
    // transmit state from the protocol engine
    input  wire logic                    TX_ACTIVE,
    input  wire logic                    ARB_LOST,
    input  wire logic                    LOOPBACK,
    // status toward the engine and interrupt logic
    output logic                         ACK_ENABLE,
    output logic                         RX_FULL,
    output logic                         RX_EVENT,
    output logic                         OVERRUN
);

    // ************************************************************
    // storage and control state
    // ************************************************************
    crx_pkg::crx_state_type state, next_state;
    logic [7:0]  bg [0:`CRX_MSG_BYTES-1];
    logic [7:0]  fifo [0:`CRX_STAGES-1][0:`CRX_MSG_BYTES-1];
    logic [`CRX_PTR_W-1:0] wr_ptr, next_wr_ptr;
    logic [`CRX_PTR_W-1:0] rd_ptr, next_rd_ptr;
    logic [`CRX_PTR_W-1:0] count, next_count;
    logic [3:0]  byte_cnt, next_byte_cnt;
    logic        own_frame, next_own_frame;
    logic [7:0]  cfg, next_cfg;
    logic [7:0]  value [0:7];
    logic [7:0]  mask  [0:7];
    logic [2:0]  hit_idx_fg [0:`CRX_STAGES-1];
    logic [2:0]  last_hit, next_last_hit;
    logic        overrun, next_overrun;
    logic        rx_evt, next_rx_evt;
    logic [7:0]  rdata, next_rdata;

    crx_filt_if fi();
    logic [63:0] value_flat;
    logic [63:0] mask_flat;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [`CRX_PTR_W-1:0] ptr_inc(
        input logic [`CRX_PTR_W-1:0] p);
        if (p == `CRX_PTR_W'(`CRX_STAGES - 1)) begin
            ptr_inc = '0;
        end else begin
            ptr_inc = p + `CRX_PTR_W'(1);
        end
    endfunction

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            value_flat[i*8 +: 8] = value[i];
            mask_flat[i*8 +: 8]  = mask[i];
        end
        for (int i = 0; i < 4; i++) begin
            fi.id_byte[i] = bg[i];
        end
        fi.mode = cfg[`CRX_CFG_MODE_LSB +: 2];
    end

    crx_filter u_filter (
        .fi    (fi.filt),
        .VALUE (value_flat),
        .MASK  (mask_flat)
    );

    // ************************************************************
    // frame sequencing and fifo control
    // ************************************************************
    logic full_now;
    logic store;
    logic discard;
    logic pop;
    logic wr_cfg;

    always_comb begin
        full_now = (count == `CRX_PTR_W'(`CRX_STAGES));
        // own frame kept out unless loopback or arbitration lost
        store    = 1'b0;
        discard  = 1'b0;
        if (state == crx_pkg::CRX_FRAME && FRAME_OK && fi.hit &&
            !own_frame) begin
            store   = !full_now;
            discard = full_now;
        end
        pop = WR && ADDR == `CRX_OFF_FLAGS && WDATA[`CRX_FLG_FULL] &&
              count != '0;
        wr_cfg = WR && ADDR == `CRX_OFF_CONFIG;
    end

    always_comb begin
        next_state     = state;
        next_byte_cnt  = byte_cnt;
        next_own_frame = own_frame;
        next_wr_ptr    = wr_ptr;
        next_rd_ptr    = rd_ptr;
        next_count     = count;
        next_last_hit  = last_hit;
        next_overrun   = overrun;
        next_rx_evt    = 1'b0;
        next_cfg       = cfg;
        unique case (state)
            crx_pkg::CRX_IDLE: begin
                if (FRAME_START) begin
                    next_state     = crx_pkg::CRX_FRAME;
                    next_byte_cnt  = '0;
                    next_own_frame = TX_ACTIVE && !LOOPBACK;
                end
            end
            crx_pkg::CRX_FRAME: begin
                if (ARB_LOST) begin
                    next_own_frame = 1'b0;
                end
                if (BYTE_VALID &&
                    byte_cnt != 4'(`CRX_MSG_BYTES)) begin
                    next_byte_cnt = byte_cnt + 4'h1;
                end
                if (FRAME_OK || FRAME_ERR) begin
                    // rejected or broken frame simply stays behind
                    next_state = crx_pkg::CRX_DONE;
                end
            end
            crx_pkg::CRX_DONE: begin
                next_state = crx_pkg::CRX_IDLE;
                if (FRAME_START) begin
                    next_state     = crx_pkg::CRX_FRAME;
                    next_byte_cnt  = '0;
                    next_own_frame = TX_ACTIVE && !LOOPBACK;
                end
            end
        endcase
        if (store) begin
            next_wr_ptr   = ptr_inc(wr_ptr);
            next_rx_evt   = 1'b1;
            next_last_hit = fi.hit_index;
        end
        if (pop) begin
            next_rd_ptr = ptr_inc(rd_ptr);
        end
        next_count = count + `CRX_PTR_W'(store) - `CRX_PTR_W'(pop);
        // software clear loses to a fresh overrun
        if (WR && ADDR == `CRX_OFF_FLAGS && WDATA[`CRX_FLG_OVERRUN]) begin
            next_overrun = 1'b0;
        end
        if (discard) begin
            next_overrun = 1'b1;
        end
        if (wr_cfg) begin
            next_cfg = {2'h0, WDATA[`CRX_CFG_MODE_LSB +: 2], 4'h0};
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state     <= crx_pkg::CRX_IDLE;
            byte_cnt  <= '0;
            own_frame <= 1'b0;
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            last_hit  <= 3'h0;
            overrun   <= 1'b0;
            rx_evt    <= 1'b0;
            cfg       <= `CRX_CFG_RESET;
        end else begin
            state     <= next_state;
            byte_cnt  <= next_byte_cnt;
            own_frame <= next_own_frame;
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            last_hit  <= next_last_hit;
            overrun   <= next_overrun;
            rx_evt    <= next_rx_evt;
            cfg       <= next_cfg;
        end
    end

    // ************************************************************
    // message arrays, filter registers
    // ************************************************************
    // arrays without reset: foreground bytes can be read before any message is flagged valid
    always_ff @(posedge CLK) begin
        if (state == crx_pkg::CRX_FRAME && BYTE_VALID &&
            byte_cnt != 4'(`CRX_MSG_BYTES)) begin
            bg[byte_cnt] <= BYTE_DATA;
        end
        if (store) begin
            for (int b = 0; b < `CRX_MSG_BYTES; b++) begin
                fifo[wr_ptr][b] <= bg[b];
            end
            hit_idx_fg[wr_ptr] <= fi.hit_index;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 8; i++) begin
                value[i] <= 8'h00;
                mask[i]  <= 8'hff;
            end
        end else if (WR && ADDR[7:4] == 4'(`CRX_OFF_VALUE0 >> 4)) begin
            if (ADDR[3]) begin
                mask[ADDR[2:0]] <= WDATA;
            end else begin
                value[ADDR[2:0]] <= WDATA;
            end
        end
    end

    // ************************************************************
    // read port: one cycle latency
    // ************************************************************
    always_comb begin
        next_rdata = 8'h00;
        if (RD) begin
            if (ADDR == `CRX_OFF_CONFIG) begin
                next_rdata = {cfg[7:3], (count != '0) ?
                              hit_idx_fg[rd_ptr] : 3'h0};
            end else if (ADDR == `CRX_OFF_FLAGS) begin
                next_rdata = {7'h00, count != '0} |
                             {6'h00, overrun, 1'b0};
            end else if (ADDR[7:4] == 4'(`CRX_OFF_VALUE0 >> 4)) begin
                next_rdata = ADDR[3] ? mask[ADDR[2:0]]
                                     : value[ADDR[2:0]];
            end else if (ADDR >= `CRX_OFF_FG0 &&
                         ADDR < `CRX_OFF_FG0 + 8'(`CRX_MSG_BYTES)) begin
                next_rdata = fifo[rd_ptr][4'(ADDR - `CRX_OFF_FG0)];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign RDATA      = rdata;
    assign RX_FULL    = (count != '0);
    assign RX_EVENT   = rx_evt;
    assign OVERRUN    = overrun;
    assign ACK_ENABLE = !own_frame;

endmodule // crx_rx

// File: test/crx_node_model.sv
// far-side node model: delivers frames byte by byte to the receive path
`timescale 1ns/10ps
module crx_node_model (
    // clock
    input  wire logic        CLK,
    // frame link
    output logic             FRAME_START,
    output logic             BYTE_VALID,
    output logic [7:0]       BYTE_DATA,
    output logic             FRAME_OK,
    output logic             FRAME_ERR,
    output logic             ARB_LOST
);
    initial begin
        FRAME_START = 1'b0;
        BYTE_VALID = 1'b0;
        BYTE_DATA = 8'h00;
        FRAME_OK = 1'b0;
        FRAME_ERR = 1'b0;
        ARB_LOST = 1'b0;
    end
    // end pulses drop here so a new frame may start in the done cycle
    always @(posedge CLK) begin
        if (FRAME_OK || FRAME_ERR) begin
            FRAME_OK <= 1'b0;
            FRAME_ERR <= 1'b0;
        end
    end
    task automatic send(input crx_pkg::crx_msg_type m, input logic ok, lose,
                        input int gap);
        @(posedge CLK);
        FRAME_START <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            @(posedge CLK);
            FRAME_START <= 1'b0;
            ARB_LOST <= lose && (i == 1);
            BYTE_VALID <= 1'b1;
            BYTE_DATA <= m[i];
            // slow delivery: stale data inverted so it never looks valid
            for (int g = 0; g < gap; g++) begin
                @(posedge CLK);
                ARB_LOST <= 1'b0;
                BYTE_VALID <= 1'b0;
                BYTE_DATA <= ~BYTE_DATA;
            end
        end
        @(posedge CLK);
        ARB_LOST <= 1'b0;
        BYTE_VALID <= 1'b0;
        BYTE_DATA <= ~BYTE_DATA;
        FRAME_OK <= ok;
        FRAME_ERR <= !ok;
    endtask
endmodule // crx_node_model

// File: test/crx_rx_sva.sv
// port-level assertion checker for the can receive path
`timescale 1ns/10ps
`include "crx_defs.svh"
module crx_rx_sva (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    // register port
    input  wire logic [`CRX_ADDR_W-1:0] ADDR,
    input  wire logic [7:0]             WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    input  wire logic [7:0]             RDATA,
    // frame link
    input  wire logic                   FRAME_START,
    input  wire logic                   FRAME_OK,
    input  wire logic                   FRAME_ERR,
    input  wire logic                   TX_ACTIVE,
    input  wire logic                   LOOPBACK,
    // status
    input  wire logic                   ACK_ENABLE,
    input  wire logic                   RX_FULL,
    input  wire logic                   RX_EVENT,
    input  wire logic                   OVERRUN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ***************
    // closed mode tracker
    // ***************
    logic closed;
    logic next_closed;
    always_comb begin
        next_closed = closed;
        if (WR && ADDR == `CRX_OFF_CONFIG)
            next_closed = (WDATA[5:4] == `CRX_MODE_CLOSED);
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            closed <= 1'b0;
        else
            closed <= next_closed;
    end
    // ***************
    // assertions
    // ***************
    AST_EVENT_CAUSE: assert property (
        RX_EVENT |-> $past(FRAME_OK) && RX_FULL)
        else $error("receive event without a good frame end");
    AST_EVENT_PULSE: assert property (RX_EVENT |=> !RX_EVENT)
        else $error("receive event longer than one cycle");
    AST_ERR_DROP: assert property (FRAME_ERR |=> !RX_EVENT)
        else $error("failed frame was stored");
    AST_FULL_RISE: assert property ($rose(RX_FULL) |-> RX_EVENT)
        else $error("full flag rose without a store");
    AST_OVR_CAUSE: assert property (
        $rose(OVERRUN) |-> $past(FRAME_OK) && RX_FULL && !RX_EVENT)
        else $error("overrun without a discarded good frame");
    AST_OVR_HOLD: assert property (
        OVERRUN && !(WR && ADDR == `CRX_OFF_FLAGS && WDATA[1])
        |=> OVERRUN)
        else $error("overrun dropped without a clear");
    AST_OWN_NOACK: assert property (
        FRAME_START && TX_ACTIVE && !LOOPBACK |=> !ACK_ENABLE)
        else $error("own frame acknowledged");
    AST_LOOP_ACK: assert property (
        FRAME_START && LOOPBACK |=> ACK_ENABLE)
        else $error("loopback frame not acknowledged");
    AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside read answer cycle");
    AST_CLOSED: assert property (
        closed && FRAME_OK |=> !RX_EVENT)
        else $error("closed filter stored a frame");
    cover property (RX_EVENT);
    cover property ($rose(OVERRUN));
    cover property (FRAME_START && TX_ACTIVE && LOOPBACK);
endmodule // crx_rx_sva

bind crx_rx crx_rx_sva i_crx_rx_sva (.CLK(CLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FRAME_START(FRAME_START), .FRAME_OK(FRAME_OK), .FRAME_ERR(FRAME_ERR),
    .TX_ACTIVE(TX_ACTIVE), .LOOPBACK(LOOPBACK), .ACK_ENABLE(ACK_ENABLE),
    .RX_FULL(RX_FULL), .RX_EVENT(RX_EVENT), .OVERRUN(OVERRUN));

// File: test/testbench.sv
// self-checking bench for the can receive path
`timescale 1ns/10ps
`include "crx_defs.svh"
module testbench;
    logic                   CLK, RESET_N, WR, RD, TX_ACTIVE, LOOPBACK;
    logic [`CRX_ADDR_W-1:0] ADDR;
    logic [7:0]             WDATA, RDATA, BYTE_DATA;
    logic                   FRAME_START, BYTE_VALID, FRAME_OK, FRAME_ERR;
    logic                   ARB_LOST, ACK_ENABLE, RX_FULL, RX_EVENT, OVERRUN;
    logic                   rd_q;
    int                     fail_count, n_compared, seed, k;
    string                  qn[$];
    logic [7:0]             qe[$];
    crx_pkg::crx_msg_type   msg;
    // {id byte 0, good end, lost arbitration, transmitting, loopback, full}
    logic [12:0]            cases [5] = '{13'h050, 13'h020, 13'h034,
                                          13'h037, 13'h03d};
    logic [7:0]             order [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};

    crx_rx i_crx_rx (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .FRAME_START(FRAME_START), .BYTE_VALID(BYTE_VALID),
        .BYTE_DATA(BYTE_DATA), .FRAME_OK(FRAME_OK), .FRAME_ERR(FRAME_ERR),
        .TX_ACTIVE(TX_ACTIVE), .ARB_LOST(ARB_LOST), .LOOPBACK(LOOPBACK),
        .ACK_ENABLE(ACK_ENABLE), .RX_FULL(RX_FULL), .RX_EVENT(RX_EVENT),
        .OVERRUN(OVERRUN));
    crx_node_model i_crx_node_model (.CLK(CLK), .FRAME_START(FRAME_START),
        .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
        .FRAME_OK(FRAME_OK), .FRAME_ERR(FRAME_ERR), .ARB_LOST(ARB_LOST));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ***************
    // monitor: read answers checked against the oldest note
    // ***************
    always @(posedge CLK) rd_q <= RD;
    always @(negedge CLK) begin
        if (rd_q && qe.size() > 0)
            chk(qn.pop_front(), qe.pop_front(), RDATA);
    end
    task automatic wr(input logic [7:0] a, d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, input string nm);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        qn.push_back(nm);
        qe.push_back(e);
        @(posedge CLK);
        RD <= 1'b0;
    endtask
    // distinct bank values; filter k masks bit 7, top filter ignores all
    task automatic setup(input int m, f);
        int nb;
        nb = (m == 3) ? 1 : (4 >> m);
        for (int j = 0; j < 8; j++) begin
            wr(`CRX_OFF_VALUE0 + 8'(j), 8'(16 * j + 1));
            wr(`CRX_OFF_MASK0 + 8'(j), (j >= 8 - nb) ? 8'hff :
               ((j / nb == f) ? 8'h80 : 8'h00));
        end
        wr(`CRX_OFF_CONFIG, 8'(m << `CRX_CFG_MODE_LSB));
    endtask
    task automatic fill();
        for (int b = 0; b < 15; b++)
            msg[b] = 8'($random(seed));
    endtask
    task automatic frame(input logic ok, lose, input int gap,
                         input logic [7:0] ef);
        i_crx_node_model.send(msg, ok, lose, gap);
        rd(`CRX_OFF_FLAGS, ef, "flags");
    endtask
    task automatic summarize();
        repeat (3) @(posedge CLK);
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        summarize();
    end
    initial begin
        seed = 32'h475f;
        RESET_N = 1'b0;
        {WR, RD, TX_ACTIVE, LOOPBACK, ADDR, WDATA} = '0;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(`CRX_OFF_CONFIG, `CRX_CFG_RESET, "config");
        rd(`CRX_OFF_FLAGS, 8'h00, "flags");
        rd(`CRX_OFF_MASK0 + 8'h07, 8'hff, "mask");
        rd(8'h40, 8'h00, "unmapped");
        $display("test reset done");
        // split modes preferred for short identifiers
        for (int m = 0; m < 3; m++) begin
            k = $unsigned($random(seed)) % (2 << m);
            setup(m, k);
            fill();
            for (int b = 0; b < (4 >> m); b++)
                msg[b] = 8'(16 * (k * (4 >> m) + b) + 1)
                         ^ (8'($random(seed)) & 8'h80);
            frame(1'b1, 1'b0, m, 8'h01);
            rd(`CRX_OFF_CONFIG, 8'((m << 4) | k), "hit_index");
            for (int b = 0; b < 15; b++)
                rd(`CRX_OFF_FG0 + 8'(b), msg[b], "head_byte");
            wr(`CRX_OFF_FLAGS, 8'h01);
            rd(`CRX_OFF_FLAGS, 8'h00, "flags");
        end
        $display("test filter modes done");
        setup(2, 0);
        wr(`CRX_OFF_MASK0 + 8'h07, 8'h00);
        for (int r = 0; r < 5; r++) begin
            fill();
            msg[0] = cases[r][12:5];
            @(posedge CLK);
            TX_ACTIVE <= cases[r][2];
            LOOPBACK <= cases[r][1];
            frame(cases[r][4], cases[r][3], 0,
                  {7'h0, cases[r][0]});
            if (cases[r][0])
                wr(`CRX_OFF_FLAGS, 8'h01);
        end
        TX_ACTIVE <= 1'b0;
        LOOPBACK <= 1'b0;
        setup(3, 0);
        frame(1'b1, 1'b0, 0, 8'h00);
        $display("test reject and own frames done");
        setup(2, 0);
        for (int i = 0; i < 6; i++) begin
            fill();
            msg[0] = 8'(i);
            i_crx_node_model.send(msg, 1'b1, 1'b0, 0);
        end
        rd(`CRX_OFF_FLAGS, 8'h03, "flags");
        rd(`CRX_OFF_FG0, 8'h00, "order");
        wr(`CRX_OFF_FLAGS, 8'h01);
        msg[0] = 8'h06;
        frame(1'b1, 1'b0, 0, 8'h03);
        for (int i = 0; i < 5; i++) begin
            rd(`CRX_OFF_FG0, order[i], "order");
            wr(`CRX_OFF_FLAGS, 8'h01);
        end
        rd(`CRX_OFF_FLAGS, 8'h02, "flags");
        wr(`CRX_OFF_FLAGS, 8'h02);
        rd(`CRX_OFF_FLAGS, 8'h00, "flags");
        $display("test overrun done");
        summarize();
    end
endmodule // testbench
